// *** serial_adc_conversion_sequencer.sv ***
/*
 Sequencer of a serial sampling converter with an AHB-Lite register
 port. The link side runs on the host's shift clock; select high is
 both shutdown and reset of the frame logic.
 Assumes an AHB-Lite master on hclk and a host that launches din and
 select changes on falling shift-clock edges.
*/
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defines.svh"

module serial_adc_conversion_sequencer
   import adc_seq_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout,
   output logic dout_oe,
   output wire logic sample_window,
   output logic converting,
   output logic single_ended_select,
   output logic chan_plus,
   output logic bit_order_select
);

   // hclk domain state
   logic [11:0] code_reg;
   logic req_tgl_reg;
   logic ack_s1_reg, ack_s2_reg;
   logic done_s1_reg, done_s2_reg, done_s3_reg;
   logic frame_s1_reg, frame_s2_reg;
   logic [14:0] last_reg;
   logic [15:0] count_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] hrdata_reg;
   logic hready_reg;

   // link domain, kept across frames
   logic req_s1_reg, req_s2_reg, req_seen_reg;
   logic [11:0] code_l_reg;
   logic [11:0] result_reg;
   logic [14:0] snap_reg;
   logic done_tgl_reg;

   // link domain, cleared by select high
   rx_state_e rx_reg;
   logic [1:0] cfg_cnt_reg;
   logic sgl_reg, odd_reg, order_reg;
   logic start_seen_reg;
   logic win_open_reg;
   logic win_shut_reg;
   logic [4:0] fall_cnt_reg;
   logic dout_reg, oe_reg, conv_reg;

   // select high holds the whole frame logic in reset
   wire link_rst_n = hresetn & ~cs_n;

   // bus decode
   wire addr_ok = hsel & htrans[1] & hready;
   wire acc_ok = addr_ok & (hsize == `HSIZE_WORD);
   wire rd_go = acc_ok & ~hwrite;
   wire wr_go = acc_ok & hwrite;
   wire code_busy = req_tgl_reg ^ ack_s2_reg;
   wire wr_code = wr_pend_reg & (wr_addr_reg == `OFF_CODE) & ~code_busy;
   wire done_evt = done_s2_reg ^ done_s3_reg;
   wire [31:0] status_word = {30'h0, frame_s2_reg, code_busy};

   // read mux; unmapped offsets read zero
   wire [31:0] rd_word =
      (haddr[7:0] == `OFF_CODE) ? {20'h0, code_reg} :
      (haddr[7:0] == `OFF_STATUS) ? status_word :
      (haddr[7:0] == `OFF_LAST) ? {17'h0, last_reg} :
      (haddr[7:0] == `OFF_COUNT) ? {16'h0, count_reg} : 32'h0;

   // zero wait states: every access completes in its first data cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hready_reg <= 1'b0;
         hrdata_reg <= 32'h0;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         hready_reg <= 1'b1;
         hrdata_reg <= rd_go ? rd_word : 32'h0;
         wr_pend_reg <= wr_go;
         wr_addr_reg <= haddr[7:0];
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = hready_reg;
   assign hresp = 1'b0;

   // code word for the next conversion; held still until the link
   // side has copied it, so writes while busy are dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         code_reg <= `CODE_RST;
         req_tgl_reg <= 1'b0;
      end else if (wr_code) begin
         code_reg <= hwdata[11:0];
         req_tgl_reg <= ~req_tgl_reg;
      end
   end

   // synchronisers into hclk
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
         done_s1_reg <= 1'b0;
         done_s2_reg <= 1'b0;
         done_s3_reg <= 1'b0;
         frame_s1_reg <= 1'b0;
         frame_s2_reg <= 1'b0;
      end else begin
         ack_s1_reg <= req_seen_reg;
         ack_s2_reg <= ack_s1_reg;
         done_s1_reg <= done_tgl_reg;
         done_s2_reg <= done_s1_reg;
         done_s3_reg <= done_s2_reg;
         frame_s1_reg <= ~cs_n;
         frame_s2_reg <= frame_s1_reg;
      end
   end

   // snapshot is stable for a whole conversion once the toggle moves
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_reg <= 15'h0;
         count_reg <= `COUNT_RST;
      end else if (done_evt) begin
         last_reg <= snap_reg;
         count_reg <= count_reg + 16'h1;
      end else if (wr_pend_reg && wr_addr_reg == `OFF_COUNT) begin
         count_reg <= `COUNT_RST;
      end
   end

   // code word crossing; the copy lands on the third rising shift-clock
   // edge after the write, whether select is low or high
   always_ff @(posedge sclk or negedge hresetn) begin
      if (!hresetn) begin
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         req_seen_reg <= 1'b0;
         code_l_reg <= `CODE_RST;
      end else begin
         req_s1_reg <= req_tgl_reg;
         req_s2_reg <= req_s1_reg;
         req_seen_reg <= req_s2_reg;
         if (req_s2_reg != req_seen_reg) begin
            code_l_reg <= code_reg;
         end
      end
   end

   // receive side samples din on rising edges
   wire rx_start = (rx_reg == RX_WAIT) & din;
   wire cfg_last = (rx_reg == RX_CFG) & (cfg_cnt_reg == 2'd2);

   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_reg <= RX_WAIT;
         cfg_cnt_reg <= 2'd0;
         start_seen_reg <= 1'b0;
      end else begin
         unique case (rx_reg)
            RX_WAIT: begin
               if (rx_start) begin
                  rx_reg <= RX_CFG;
                  start_seen_reg <= 1'b1;
               end
            end
            RX_CFG: begin
               cfg_cnt_reg <= cfg_cnt_reg + 2'd1;
               if (cfg_last) begin
                  rx_reg <= RX_DONE;
               end
            end
            RX_DONE: rx_reg <= RX_DONE; // further din ignored
            default: rx_reg <= RX_WAIT;
         endcase
      end
   end

   // configuration bits in arrival order
   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sgl_reg <= 1'b0;
         odd_reg <= 1'b0;
         order_reg <= 1'b0;
      end else if (rx_reg == RX_CFG) begin
         if (cfg_cnt_reg == 2'd0) sgl_reg <= din;
         if (cfg_cnt_reg == 2'd1) odd_reg <= din;
         if (cfg_cnt_reg == 2'd2) order_reg <= din;
      end
   end

   // input pairing: chan_plus names the + channel; single ended puts
   // ground on the - side, else the other channel
   assign single_ended_select = sgl_reg;
   assign chan_plus = odd_reg;
   assign bit_order_select = order_reg;

   // window opens as the bit before the order bit is taken and shuts
   // on the fall after the order bit: one and a half cycles
   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         win_open_reg <= 1'b0;
      end else if (rx_reg == RX_CFG && cfg_cnt_reg == 2'd1) win_open_reg <= 1'b1;
   end

   always_ff @(negedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         win_shut_reg <= 1'b0;
      end else if (fall_cnt_reg == `FALL_TAKE) win_shut_reg <= 1'b1;
   end

   // two edges shape this one, so it cannot come from a single flop
   assign sample_window = win_open_reg & ~win_shut_reg;

   // falls counted from the first fall after the start bit
   always_ff @(negedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         fall_cnt_reg <= 5'd0;
      end else if (start_seen_reg && fall_cnt_reg != `FALL_SAT) begin
         fall_cnt_reg <= fall_cnt_reg + 5'd1;
      end
   end

   // output bit for each fall; zeros outside the data
   wire in_msb = (fall_cnt_reg > `FALL_TAKE) & (fall_cnt_reg <= `FALL_DONE);
   wire in_lsb = (fall_cnt_reg > `FALL_DONE) &
                 (fall_cnt_reg <= `FALL_LSB_END) & ~order_reg;
   wire [3:0] msb_idx = 4'(`FALL_DONE - fall_cnt_reg);
   wire [3:0] lsb_idx = 4'(fall_cnt_reg - `FALL_DONE);
   wire dout_next = (in_msb & result_reg[msb_idx]) |
                    (in_lsb & result_reg[lsb_idx]);
   wire take_fall = (fall_cnt_reg == `FALL_TAKE);
   wire done_fall = (fall_cnt_reg == `FALL_DONE);

   // launches on falling edges; drives the line from the fourth fall
   always_ff @(negedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         oe_reg <= 1'b0;
         dout_reg <= 1'b0;
      end else begin
         if (take_fall) oe_reg <= 1'b1;
         dout_reg <= take_fall ? 1'b0 : dout_next;
      end
   end

   // converter powered only between the take fall and the done fall,
   // whatever select does after that
   always_ff @(negedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         conv_reg <= 1'b0;
      end else if (take_fall) begin
         conv_reg <= 1'b1;
      end else if (done_fall) begin
         conv_reg <= 1'b0;
      end
   end

   // held result and hand-off to hclk; these survive select high so
   // the bus still sees a conversion finished just before the abort
   always_ff @(negedge sclk or negedge hresetn) begin
      if (!hresetn) begin
         result_reg <= 12'h0;
         snap_reg <= 15'h0;
         done_tgl_reg <= 1'b0;
      end else if (link_rst_n && take_fall) begin
         result_reg <= code_l_reg;
      end else if (link_rst_n && done_fall) begin
         snap_reg <= {order_reg, odd_reg, sgl_reg, result_reg};
         done_tgl_reg <= ~done_tgl_reg;
      end
   end

   assign dout = dout_reg;
   assign dout_oe = oe_reg;
   assign converting = conv_reg;

   // line stays released until the fourth fall after the start bit
   a_oe_takes_line: assert property (
      @(negedge sclk) disable iff (cs_n)
      (fall_cnt_reg == `FALL_TAKE) |=> (dout_oe && !dout))
      else $error("line not driven low on fourth fall");

   a_oe_not_early: assert property (
      @(negedge sclk) disable iff (cs_n)
      (fall_cnt_reg <= `FALL_TAKE) |-> !dout_oe)
      else $error("line driven before fourth fall");

   a_shutdown_idle: assert property (
      @(posedge sclk) disable iff (!hresetn)
      cs_n |-> (!converting && !dout_oe && rx_reg == RX_WAIT))
      else $error("activity while select high");

   a_conv_twelve: assert property (
      @(negedge sclk) disable iff (cs_n)
      (fall_cnt_reg == `FALL_TAKE) |=>
         converting [*8] ##1 converting [*4] ##1 !converting)
      else $error("conversion not twelve cycles");

   a_power_down: assert property (
      @(negedge sclk) disable iff (cs_n)
      $fell(converting) |-> (dout_oe && fall_cnt_reg == 5'd16))
      else $error("power-down not at end of conversion");

   a_keeps_shift: assert property (
      @(negedge sclk) disable iff (cs_n)
      (fall_cnt_reg > 5'd16) |-> (dout_oe && !converting))
      else $error("output released after conversion");

   a_window_span: assert property (
      @(negedge sclk) disable iff (cs_n)
      (fall_cnt_reg == `FALL_TAKE) |-> sample_window ##1 !sample_window)
      else $error("window not closed at conversion start");

   a_window_opens: assert property (
      @(posedge sclk) disable iff (cs_n)
      (rx_reg == RX_CFG && cfg_cnt_reg == 2'd1) |=> sample_window)
      else $error("window not open on bit before order bit");

   a_hold_value: assert property (
      @(negedge sclk) disable iff (cs_n)
      (fall_cnt_reg == `FALL_TAKE) |=> (result_reg == $past(code_l_reg)))
      else $error("held value not captured at start");

   a_zero_skip: assert property (
      @(posedge sclk) disable iff (cs_n)
      (rx_reg == RX_WAIT && !din) |=> (rx_reg == RX_WAIT))
      else $error("leading zero taken as start");

   a_msb_zeros: assert property (
      @(negedge sclk) disable iff (cs_n)
      (bit_order_select && fall_cnt_reg > 5'd16) |-> !dout)
      else $error("nonzero after data in msb-only mode");

   a_lsb_copy: assert property (
      @(negedge sclk) disable iff (cs_n)
      (!bit_order_select && fall_cnt_reg == 5'd17) |->
         (dout == result_reg[1]) ##1 (dout == result_reg[2]))
      else $error("lsb copy out of order");

   a_pairing: assert property (
      @(posedge sclk) disable iff (cs_n)
      (rx_reg == RX_CFG && cfg_cnt_reg == 2'd0) |=>
         (single_ended_select == $past(din)))
      else $error("pairing bit not taken after start");

endmodule
`default_nettype wire

// *** adc_seq_defines.svh ***
/*
 Constants of the serial conversion sequencer: register offsets,
 field positions, reset values and shift-clock counts.
 Assumes inclusion by bare name; holds definitions only.
*/
// Function
// - shared wire: drive low on fourth fall
// - select high: fully idle, pins ignored; shift clock still copies a pending code word
// - power down after conversion, keep shifting
// - auto power-down even with select low
// - window opens on bit before order bit
// - fall after order bit: hold, start conversion
// - conversion lasts exactly twelve clock cycles
// - window lasts one and half cycles
// - launch on falling edge, sample on rising
// - skip leading zeros; first one starts
// - two bits after start pick channel pairing
// - order bit picks zeros or LSB copy
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// register byte offsets, compared against haddr[7:0]
`define OFF_CODE 8'h00
`define OFF_STATUS 8'h04
`define OFF_LAST 8'h08
`define OFF_COUNT 8'h0c

// field positions
`define ST_BUSY 0
`define ST_FRAME 1
`define LAST_SGL 12
`define LAST_ODD 13
`define LAST_ORDER 14

// reset values
`define CODE_RST 12'h000
`define COUNT_RST 16'h0000

// falling-edge counts, counted from the first fall after the start bit
`define FALL_TAKE 5'd3
`define CONV_CYCLES 5'd12
`define FALL_DONE (`FALL_TAKE + `CONV_CYCLES)
`define FALL_LSB_END 5'd26
`define FALL_SAT 5'd27

// word transfer size on the bus
`define HSIZE_WORD 3'h2

`endif

// *** adc_seq_pkg.sv ***
/*
 Types of the serial conversion sequencer.
 Assumes nothing of its surroundings.
*/
package adc_seq_pkg;
   // receive state, gray coded along start -> config -> done
   typedef enum logic [1:0] {
      RX_WAIT = 2'b00,
      RX_CFG = 2'b01,
      RX_DONE = 2'b11
   } rx_state_e;
endpackage

// *** host_link_model.sv ***
/*
 Host side of the shared serial data wire: makes the shift clock inside
 frames and as deselected noise, drives select and its own data bit, then listens.
 Assumes the bench resolves the wire from both output enables.
*/
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
   output logic sclk,
   output logic cs_n,
   output logic host_bit,
   output logic host_oe,
   input wire logic line,
   input wire logic dout_oe
);
   // the clock ceiling guards analog settling, which is not modelled here;
   // the logic itself has no speed limit, so the bench clocks far faster
   localparam int half = 24;
   logic oe_ok;

   // idle: clock low, deselected, pin released
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      host_bit = 1'b0;
      host_oe = 1'b0;
      oe_ok = 1'b0;
   end

   // bit launched at the fall that starts the pulse, captured at its rise
   task automatic pulse(input logic b);
      host_bit = b;
      #half sclk = 1'b1;
      #half sclk = 1'b0;
   endtask

   // one whole frame; rx[0] is the null bit, then the result and the tail
   task automatic frame(input logic [2:0] cfg, input int nrx, output logic [39:0] rx);
      rx = '0;
      #7 cs_n = 1'b0;
      host_oe = 1'b1;
      pulse(1'b0);
      pulse(1'b0);
      pulse(1'b1);
      pulse(cfg[2]);
      pulse(cfg[1]);
      host_bit = cfg[0];
      #half sclk = 1'b1;
      // let go right after the last rise, a half cycle before the takeover
      #1 host_oe = 1'b0;
      oe_ok = (dout_oe === 1'b0);
      #(half - 1) sclk = 1'b0;
      #1 oe_ok = oe_ok && (dout_oe === 1'b1);
      // listen, then leave the clock standing low
      for (int i = 0; i < nrx; i++) begin
         #(half - 1) sclk = 1'b1;
         rx[i] = line;
         #half sclk = 1'b0;
         #1;
      end
   endtask

   // deselect at once after the transfer, to save power
   task automatic finish;
      #7 cs_n = 1'b1;
      #1;
   endtask

   // clock and ones keep running while deselected
   task automatic noise(input int n);
      host_oe = 1'b1;
      for (int i = 0; i < n; i++) pulse(1'b1);
      host_oe = 1'b0;
   endtask
endmodule
`default_nettype wire

// *** serial_adc_conversion_sequencer_tb_top.sv ***
/*
 Self-checking bench of the conversion sequencer: bus tasks, one task
 per scenario, a host model on the shared data wire.
 Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defines.svh"
module serial_adc_conversion_sequencer_tb_top;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b1;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = `HSIZE_WORD;
   logic idle_lvl = 1'b0;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, sclk, cs_n, host_bit, host_oe, dout, dout_oe, line;
   wire logic sample_window, converting, single_ended_select, chan_plus, bit_order_select;
   int n_fail = 0;
   int tests_run = 0;
   int conv_rises = 0;
   realtime t_open, t_win, t_hold;

   always #5 hclk = ~hclk;
   // a released wire toggles each cycle so a stale level cannot pass for data
   always @(posedge hclk) idle_lvl <= ~idle_lvl;
   assign line = dout_oe ? dout : (host_oe ? host_bit : idle_lvl);

   serial_adc_conversion_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclk(sclk), .cs_n(cs_n), .din(line),
      .dout(dout), .dout_oe(dout_oe), .sample_window(sample_window), .converting(converting),
      .single_ended_select(single_ended_select), .chan_plus(chan_plus), .bit_order_select(bit_order_select));
   host_link_model host (.sclk(sclk), .cs_n(cs_n), .host_bit(host_bit), .host_oe(host_oe),
      .line(line), .dout_oe(dout_oe));

   // timing probes of the sampling window and the conversion
   always @(posedge sample_window) t_open = $realtime;
   always @(negedge sample_window) t_win = $realtime - t_open;
   always @(posedge converting) t_hold = $realtime - t_open;
   always @(posedge sclk) if (converting === 1'b1) conv_rises++;
   // no double drive on the wire; nothing moves while deselected
   always @(posedge hclk) if (dout_oe === 1'b1 && host_oe) chk32(32'h1, 32'h0);
   always @(negedge sclk) if (cs_n) chk32({29'h0, dout_oe, converting, sample_window}, 32'h0);

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // address phase held until hready, then the data phase
   task automatic ahb_addr(input logic [7:0] a, input logic w);
      @(posedge hclk);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
   endtask

   task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
      ahb_addr(a, 1'b1);
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      ahb_addr(a, 1'b0);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      chk32(hrdata, exp);
   endtask

   // reset values, read-only places and an unmapped offset
   task automatic t_regs;
      rd_chk(`OFF_CODE, 32'h0);
      rd_chk(`OFF_STATUS, 32'h0);
      ahb_write(`OFF_LAST, 32'hffff_ffff);
      rd_chk(`OFF_LAST, 32'h0);
      ahb_write(8'h40, 32'h1234_5678);
      rd_chk(8'h40, 32'h0);
      // a byte-sized write must leave the code alone
      hsize <= 3'h0;
      ahb_write(`OFF_CODE, 32'h0000_07ff);
      hsize <= `HSIZE_WORD;
      rd_chk(`OFF_CODE, 32'h0);
      chk32({31'h0, hresp}, 32'h0);
   endtask

   // whole frame: takeover, window, conversion length, data and tail
   task automatic t_conv(input logic [2:0] cfg, input logic [11:0] code);
      logic [39:0] rx, exp;
      ahb_write(`OFF_CODE, {20'h0, code});
      conv_rises = 0;
      host.frame(cfg, 40, rx);
      exp = '0;
      for (int i = 0; i < 12; i++) exp[1 + i] = code[11 - i];
      if (!cfg[0]) for (int i = 1; i < 12; i++) exp[12 + i] = code[i];
      chk32({31'h0, host.oe_ok}, 32'h1);
      chk32(32'(int'(t_win)), 32'h48);
      chk32(32'(int'(t_hold)), 32'h48);
      chk32(32'(conv_rises), 32'h0c);
      chk32({30'h0, converting, dout_oe}, 32'h1);
      chk32({29'h0, single_ended_select, chan_plus, bit_order_select}, {29'h0, cfg});
      chk32(rx[31:0], exp[31:0]);
      chk32({24'h0, rx[39:32]}, {24'h0, exp[39:32]});
      host.finish();
      chk32({30'h0, dout_oe, converting}, 32'h0);
      rd_chk(`OFF_LAST, {17'h0, cfg[0], cfg[1], cfg[2], code});
   endtask

   // select rises mid-conversion: all drops and nothing is counted
   task automatic t_abort;
      logic [39:0] rx;
      host.frame(3'b101, 5, rx);
      chk32({31'h0, converting}, 32'h1);
      rd_chk(`OFF_STATUS, 32'h2);
      host.finish();
      chk32({29'h0, dout_oe, converting, sample_window}, 32'h0);
      rd_chk(`OFF_COUNT, 32'h8);
   endtask

   // pins toggle while deselected; no frame may start
   task automatic t_idle;
      // a code waits busy until the shift clock copies it; a second write is dropped
      ahb_write(`OFF_CODE, 32'h0000_05a5);
      rd_chk(`OFF_STATUS, 32'h1);
      ahb_write(`OFF_CODE, 32'h0000_0123);
      rd_chk(`OFF_CODE, 32'h0000_05a5);
      host.noise(12);
      rd_chk(`OFF_STATUS, 32'h0);
      rd_chk(`OFF_COUNT, 32'h8);
      ahb_write(`OFF_COUNT, 32'h0);
      rd_chk(`OFF_COUNT, 32'h0);
   endtask

   // main sequence: every pairing with both bit orders, then the odd cases
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      for (int c = 0; c < 8; c++) t_conv(c[2:0], 12'h9b4 ^ {4{c[2:0]}});
      t_abort();
      t_idle();
      t_conv(3'b110, 12'hfff);
      wrap_up();
   end

   // the run needs about 22 us; a hang past 200 us ends it as a failure
   initial begin
      #200_000;
      n_fail++;
      wrap_up();
   end
endmodule
`default_nettype wire
